// [cis_host.sv]
// Host end: power-up wait, reference level, reset pulse, serial access.
// Assumes a shared sampling clock and that power came up at reset.
//
// How it works
// RQ1 - Reset pulse high at least one microsecond
// RQ2 - Reference level set, clock running, before reset
// RQ3 - Wait two milliseconds before setting reference
// RQ4 - Reference to reset rise at least 100ns
// RQ5 - Device loads fuses then starts calibration
// RQ6 - Calibration lasts about 200000 clock cycles
// RQ7 - No serial enable until calibration ends
// RQ8 - Bit zero of reg zero resets, self-clears
// RQ9 - Reset pin stays low during software reset
// RQ10 - Wait calibration time after any reset
`timescale 1ns/100ps
`default_nettype none
module cis_host
#(
   parameter int unsigned POWER_UP_LEN = cis_pkg::POWER_UP_CYCLES,
   parameter int unsigned CAL_LEN = cis_pkg::CAL_CYCLES
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link
   cis_link_if.host link,
   // Setup
   input wire logic ref_level_i,
   // Requests
   input wire logic req_i,
   input wire logic req_read_i,
   input wire logic [cis_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [cis_pkg::DATA_W-1:0] req_data_i,
   input wire logic sw_reset_i,
   input wire logic hw_reset_i,
   // Answers
   output logic ready_o,
   output logic rd_valid_o,
   output logic [cis_pkg::DATA_W-1:0] rd_data_o
);
   import cis_pkg::*;

   typedef enum logic [2:0]
   {
      ST_POWER,
      ST_REF,
      ST_PULSE,
      ST_CAL,
      ST_IDLE,
      ST_SHIFT
   } cis_host_state_type;

   cis_host_state_type state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [3:0] bit_r;
   logic [FRAME_W-1:0] frame_r;
   logic is_read_r, is_swr_r;
   logic rst_pin_r, ref_r, sen_n_r, sclk_r;
   logic dout1_r, dout2_r;
   logic [DATA_W-1:0] rd_sh_r, rd_data_r;
   logic rd_valid_r, ready_r;

   function automatic logic hit(input logic [CNT_W-1:0] c,
      input int unsigned len);
      return c == CNT_W'(len - 1);
   endfunction

   wire any_req = hw_reset_i | sw_reset_i | req_i;
   wire half_end = hit(cnt_r, SCLK_HALF_CYCLES);
   wire last_bit = bit_r == 4'hf;
   wire [FRAME_W-1:0] sw_frame =
      {1'b0, REG_GLOBAL_SOFTWARE_RESET, 8'h01}; // RQ8
   wire [FRAME_W-1:0] req_frame = {req_read_i, req_addr_i, req_data_i};

   // Read data is synchronised before use
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         dout1_r <= 1'b0;
         dout2_r <= 1'b0;
      end
      else
      begin
         dout1_r <= link.serial_dout;
         dout2_r <= dout1_r;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_r <= ST_POWER;
         cnt_r <= '0;
         bit_r <= 4'h0;
         frame_r <= '0;
         is_read_r <= 1'b0;
         is_swr_r <= 1'b0;
         rst_pin_r <= 1'b0;
         ref_r <= 1'b0;
         sen_n_r <= 1'b1;
         sclk_r <= 1'b0;
         rd_sh_r <= 8'h00;
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
         ready_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
         rd_valid_r <= 1'b0;
         case (state_r)
            ST_POWER:
            begin
               // Bandgap settles before the reference level counts
               if (hit(cnt_r, POWER_UP_LEN)) // RQ3
               begin
                  ref_r <= ref_level_i; // RQ2
                  cnt_r <= '0;
                  state_r <= ST_REF;
               end
            end
            ST_REF:
            begin
               if (hit(cnt_r, REF_SETUP_CYCLES)) // RQ4
               begin
                  rst_pin_r <= 1'b1; // RQ1
                  cnt_r <= '0;
                  state_r <= ST_PULSE;
               end
            end
            ST_PULSE:
            begin
               if (hit(cnt_r, RESET_PULSE_CYCLES)) // RQ1
               begin
                  rst_pin_r <= 1'b0;
                  cnt_r <= '0;
                  state_r <= ST_CAL;
               end
            end
            ST_CAL:
            begin
               // Device ignores writes until calibration ends
               if (hit(cnt_r, CAL_LEN)) // RQ7 RQ10
               begin
                  ready_r <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               cnt_r <= '0;
               bit_r <= 4'h0;
               if (any_req)
                  ready_r <= 1'b0;
               if (hw_reset_i)
               begin
                  // Reference pin takes its new level here, ahead of reset
                  ref_r <= ref_level_i; // RQ2
                  state_r <= ST_REF;
               end
               else if (sw_reset_i)
               begin
                  frame_r <= sw_frame; // RQ9
                  is_read_r <= 1'b0;
                  is_swr_r <= 1'b1;
                  sen_n_r <= 1'b0;
                  state_r <= ST_SHIFT;
               end
               else if (req_i)
               begin
                  frame_r <= req_frame;
                  is_read_r <= req_read_i;
                  is_swr_r <= 1'b0;
                  sen_n_r <= 1'b0;
                  state_r <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (half_end)
               begin
                  cnt_r <= '0;
                  sclk_r <= ~sclk_r;
                  if (sclk_r)
                  begin
                     // Sample just before the falling edge
                     if (bit_r[3])
                        rd_sh_r <= {rd_sh_r[DATA_W-2:0], dout2_r};
                     frame_r <= {frame_r[FRAME_W-2:0], 1'b0};
                     bit_r <= bit_r + 4'h1;
                     if (last_bit)
                     begin
                        sen_n_r <= 1'b1;
                        if (is_read_r)
                        begin
                           rd_data_r <= {rd_sh_r[DATA_W-2:0], dout2_r};
                           rd_valid_r <= 1'b1;
                        end
                        if (is_swr_r)
                           state_r <= ST_CAL; // RQ10
                        else
                        begin
                           ready_r <= 1'b1;
                           state_r <= ST_IDLE;
                        end
                     end
                  end
               end
            end
            default: state_r <= ST_POWER;
         endcase
      end
   end

   assign link.reset_pin = rst_pin_r;
   assign link.reference_select_pin = ref_r;
   assign link.serial_port_enable_n = sen_n_r;
   assign link.serial_clk = sclk_r;
   assign link.serial_din = frame_r[FRAME_W-1];
   assign ready_o = ready_r;
   assign rd_valid_o = rd_valid_r;
   assign rd_data_o = rd_data_r;
endmodule
`default_nettype wire

// [cis_pkg.sv]
// Shared constants for the converter init/reset sequence, both ends.
// Assumes one 100 MHz sampling clock shared by host and device.
package cis_pkg;
   // Clock
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Timing figures as printed
   localparam int unsigned POWER_UP_MS = 2;
   localparam int unsigned REF_SETUP_NS = 100;
   localparam int unsigned RESET_PULSE_US = 1;
   localparam int unsigned CAL_CYCLES = 200000;
   // Least times, rounded up to whole cycles
   localparam int unsigned POWER_UP_CYCLES =
      (POWER_UP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REF_SETUP_CYCLES =
      (REF_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_PULSE_CYCLES =
      (RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Serial clock half period in system clocks
   localparam int unsigned SCLK_HALF_CYCLES = 8;
   // Counter and frame widths
   localparam int unsigned CNT_W = 18;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FRAME_W = 16;
   // Frame fields: read flag, address, data
   localparam int unsigned FRAME_RD_BIT = 15;
   localparam int unsigned FRAME_ADDR_LSB = 8;
   // Register offsets
   localparam logic [6:0] REG_GLOBAL_SOFTWARE_RESET = 7'h00;
   localparam logic [6:0] REG_STATUS = 7'h01;
   localparam logic [6:0] REG_CONFIG = 7'h02;
   // Field positions
   localparam int unsigned SW_RESET_BIT = 0;
   localparam int unsigned STATUS_BUSY_BIT = 0;
   localparam int unsigned STATUS_REF_BIT = 1;
   // Reset and fuse default values
   localparam logic [7:0] SW_RESET_DEFAULT = 8'h00;
   localparam logic [7:0] CONFIG_FUSE_DEFAULT = 8'h00;
endpackage

// [cis_link_if.sv]
// Pin-level link between the host controller and the converter.
// No clock here; both ends run on the shared sampling clock.
`timescale 1ns/100ps
`default_nettype none
interface cis_link_if;
   logic reset_pin;
   logic reference_select_pin;
   logic serial_port_enable_n;
   logic serial_clk;
   logic serial_din;
   logic serial_dout;

   modport device
   (
      input reset_pin,
      input reference_select_pin,
      input serial_port_enable_n,
      input serial_clk,
      input serial_din,
      output serial_dout
   );

   modport host
   (
      output reset_pin,
      output reference_select_pin,
      output serial_port_enable_n,
      output serial_clk,
      output serial_din,
      input serial_dout
   );
endinterface
`default_nettype wire

// [cis_device.sv]
// Converter end: reset pin, fuse load, calibration, serial registers.
// Assumes all link pins come from another party, hence synchronised.
`timescale 1ns/100ps
`default_nettype none
module cis_device
#(
   parameter int unsigned CAL_LEN = cis_pkg::CAL_CYCLES
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link
   cis_link_if.device link,
   // User side
   output logic busy_o,
   output logic ref_select_o,
   output logic [cis_pkg::DATA_W-1:0] config_o
);
   import cis_pkg::*;

   typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_CAL, ST_READY}
      cis_dev_state_type;

   cis_dev_state_type state_r, state_nxt;
   logic [4:0] sync1_r, sync2_r;
   logic sclk_q_r;
   logic [FRAME_W-2:0] sh_r;
   logic [3:0] bit_r;
   logic [DATA_W-1:0] rd_sh_r;
   logic dout_r;
   logic [CNT_W-1:0] cal_r;
   logic [DATA_W-1:0] swrst_r, config_r;
   logic ref_r, busy_r;

   wire rst_pin = sync2_r[0];
   wire ref_pin = sync2_r[1];
   wire sen_n = sync2_r[2];
   wire sclk = sync2_r[3];
   wire din = sync2_r[4];
   wire sclk_rise = sclk & ~sclk_q_r;
   wire sclk_fall = ~sclk & sclk_q_r;
   wire [FRAME_W-1:0] frame = {sh_r, din};
   wire [ADDR_W-1:0] addr = frame[FRAME_W-2:FRAME_ADDR_LSB];
   wire frame_done = sclk_rise & ~sen_n & (bit_r == 4'hf);
   // Writes during reset or calibration are dropped
   wire wr_ok = frame_done & ~frame[FRAME_RD_BIT] & (state_r == ST_READY);
   wire sw_reset = wr_ok & (addr == REG_GLOBAL_SOFTWARE_RESET) &
      frame[SW_RESET_BIT];
   wire cfg_wr = wr_ok & (addr == REG_CONFIG);
   wire addr_done = sclk_rise & ~sen_n & (bit_r == 4'h7);
   wire cal_end = cal_r == CNT_W'(CAL_LEN - 1);

   function automatic logic [7:0] reg_read(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         REG_GLOBAL_SOFTWARE_RESET: v = swrst_r;
         REG_STATUS:
         begin
            v[STATUS_BUSY_BIT] = busy_r;
            v[STATUS_REF_BIT] = ref_r;
         end
         REG_CONFIG: v = config_r;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb
   begin
      state_nxt = state_r;
      if (rst_pin)
         state_nxt = ST_HOLD; // RQ1
      else
         case (state_r)
            ST_HOLD: state_nxt = ST_LOAD; // RQ5
            ST_LOAD: state_nxt = ST_CAL; // RQ5
            ST_CAL: if (cal_end) state_nxt = ST_READY; // RQ6
            ST_READY: if (sw_reset) state_nxt = ST_LOAD; // RQ8
            default: state_nxt = ST_HOLD;
         endcase
   end

   // Pin synchronisers
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         // Presets match idle pins: reset held, enable off
         sync1_r <= 5'h05;
         sync2_r <= 5'h05;
      end
      else
      begin
         sync1_r <= {link.serial_din, link.serial_clk,
            link.serial_port_enable_n, link.reference_select_pin,
            link.reset_pin};
         sync2_r <= sync1_r;
      end
   end

   // Serial shifter; read data leaves on falling edges
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sclk_q_r <= 1'b0;
         sh_r <= '0;
         bit_r <= 4'h0;
         rd_sh_r <= 8'h00;
         dout_r <= 1'b0;
      end
      else
      begin
         sclk_q_r <= sclk;
         if (sen_n)
            bit_r <= 4'h0;
         else if (sclk_rise)
         begin
            sh_r <= frame[FRAME_W-2:0];
            bit_r <= bit_r + 4'h1;
         end
         if (addr_done)
            rd_sh_r <= reg_read(frame[ADDR_W-1:0]);
         else if (sclk_fall & ~sen_n & bit_r[3])
         begin
            dout_r <= rd_sh_r[DATA_W-1];
            rd_sh_r <= {rd_sh_r[DATA_W-2:0], 1'b0};
         end
      end
   end

   // Sequencer and registers
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_r <= ST_HOLD;
         cal_r <= '0;
         swrst_r <= SW_RESET_DEFAULT;
         config_r <= CONFIG_FUSE_DEFAULT;
         ref_r <= 1'b0;
         busy_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         busy_r <= state_nxt != ST_READY;
         cal_r <= (state_r == ST_CAL) ? cal_r + 1'b1 : '0; // RQ6
         if (state_r == ST_HOLD || state_r == ST_LOAD)
         begin
            // Fuse load also clears the reset bit itself
            swrst_r <= SW_RESET_DEFAULT; // RQ8
            config_r <= CONFIG_FUSE_DEFAULT; // RQ5
         end
         else if (sw_reset)
            swrst_r[SW_RESET_BIT] <= 1'b1; // RQ8
         else if (cfg_wr)
            config_r <= frame[DATA_W-1:0];
         // Reference level is caught once, at fuse load
         if (state_r == ST_LOAD)
            ref_r <= ref_pin;
      end
   end

   assign link.serial_dout = dout_r;
   assign busy_o = busy_r;
   assign ref_select_o = ref_r;
   assign config_o = config_r;
endmodule
`default_nettype wire

// [cis_seq_asserts.sv]
// Checker on the host-device link pins of the init/reset sequence.
// Assumes the shared clock and the shortened counts passed as params.
`timescale 1ns/100ps
`default_nettype none
module cis_seq_asserts
#(
   parameter int unsigned POWER_UP_LEN = cis_pkg::POWER_UP_CYCLES,
   parameter int unsigned CAL_LEN = cis_pkg::CAL_CYCLES
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link pins
   input wire logic reset_pin,
   input wire logic reference_select_pin,
   input wire logic serial_port_enable_n,
   input wire logic serial_clk,
   input wire logic serial_din,
   input wire logic serial_dout
);
   import cis_pkg::*;
   logic [19:0] up_cnt_r, ref_cnt_r, hi_cnt_r, quiet_cnt_r;
   logic [4:0] bit_cnt_r;
   logic [15:0] shift_r;
   logic sclk_q_r, en_q_r, ref_q_r;
   wire logic sclk_rise;
   wire logic frame_end;
   wire logic sw_frame;
   assign sclk_rise = serial_clk & ~sclk_q_r;
   assign frame_end = serial_port_enable_n & ~en_q_r;
   // A write with bit0 set to offset 0 restarts calibration once the device is ready
   assign sw_frame = frame_end & ~shift_r[15] & (shift_r[14:8] == 7'h00)
      & shift_r[0];

   function automatic logic [19:0] sat_inc(input logic [19:0] v);
      return (v == 20'hfffff) ? v : v + 20'h00001;
   endfunction

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         {sclk_q_r, en_q_r, ref_q_r} <= 3'b010;
         shift_r <= 16'h0000;
         bit_cnt_r <= 5'h00;
      end
      else
      begin
         {sclk_q_r, en_q_r, ref_q_r} <= {serial_clk, serial_port_enable_n,
            reference_select_pin};
         shift_r <= sclk_rise ? {shift_r[14:0], serial_din} : shift_r;
         bit_cnt_r <= serial_port_enable_n ? 5'h00 :
            bit_cnt_r + {4'h0, sclk_rise};
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         {up_cnt_r, ref_cnt_r, hi_cnt_r, quiet_cnt_r} <= '0;
      end
      else
      begin
         up_cnt_r <= sat_inc(up_cnt_r);
         // Change is seen one edge late, so that edge already counts
         ref_cnt_r <= (reference_select_pin != ref_q_r) ? 20'h00001 :
            sat_inc(ref_cnt_r);
         hi_cnt_r <= reset_pin ? sat_inc(hi_cnt_r) : 20'h00000;
         quiet_cnt_r <= (reset_pin | sw_frame) ? 20'h00000 :
            sat_inc(quiet_cnt_r);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence sclk_high_s;
      serial_clk [*8];
   endsequence
   sequence half_period_s;
      sclk_high_s ##1 !serial_clk;
   endsequence

   pulse_width_a: assert property (
      $fell(reset_pin) |-> hi_cnt_r >= RESET_PULSE_CYCLES)
      else $error("reset pulse too short");
   ref_hold_a: assert property (
      reset_pin |-> $stable(reference_select_pin))
      else $error("reference level moved during reset");
   power_wait_a: assert property (
      $changed(reference_select_pin) |-> up_cnt_r >= POWER_UP_LEN)
      else $error("reference level set too early");
   ref_setup_a: assert property (
      $rose(reset_pin) |-> ref_cnt_r >= REF_SETUP_CYCLES)
      else $error("reset rose too soon after reference");
   cal_quiet_a: assert property (
      $fell(serial_port_enable_n) |-> quiet_cnt_r >= CAL_LEN)
      else $error("serial frame inside calibration wait");
   pin_low_a: assert property (
      !serial_port_enable_n |-> !reset_pin)
      else $error("reset pin high during serial frame");
   frame_len_a: assert property (
      $rose(serial_port_enable_n) |-> bit_cnt_r == 5'h10)
      else $error("frame not sixteen bits");
   sclk_half_a: assert property (
      $rose(serial_clk) |-> half_period_s)
      else $error("serial clock high phase wrong");
   din_steady_a: assert property (
      serial_clk |-> $stable(serial_din))
      else $error("serial data moved while clock high");
   dout_steady_a: assert property (
      serial_clk |-> $stable(serial_dout))
      else $error("read data moved while clock high");
endmodule
`default_nettype wire

// [converter_init_reset_sequence_tb.sv]
// Self-checking bench: host end and converter end joined by the link.
// Assumes shortened power-up and calibration counts for a quick run.
`timescale 1ns/100ps
`default_nettype none
module converter_init_reset_sequence_tb;
   import cis_pkg::*;
   localparam int unsigned PU_LEN = 50;
   localparam int unsigned CAL = 64;
   // Host waits a little longer than the device calibrates
   localparam int unsigned HOST_CAL = CAL + 8;
   logic clk_i, resetn_i, ref_level_i, req_i, req_read_i;
   logic sw_reset_i, hw_reset_i, ready_o, rd_valid_o, busy_o, ref_select_o;
   logic [ADDR_W-1:0] req_addr_i, a;
   logic [DATA_W-1:0] req_data_i, rd_data_o, config_o, rdq, d;
   int fails, cmp_count, n;

   cis_link_if link_if();
   cis_device #(.CAL_LEN(CAL)) cis_device_inst (.clk_i(clk_i),
      .resetn_i(resetn_i), .link(link_if.device), .busy_o(busy_o),
      .ref_select_o(ref_select_o), .config_o(config_o));
   cis_host #(.POWER_UP_LEN(PU_LEN), .CAL_LEN(HOST_CAL)) cis_host_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .link(link_if.host),
      .ref_level_i(ref_level_i), .req_i(req_i), .req_read_i(req_read_i),
      .req_addr_i(req_addr_i), .req_data_i(req_data_i),
      .sw_reset_i(sw_reset_i), .hw_reset_i(hw_reset_i), .ready_o(ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
   cis_seq_asserts #(.POWER_UP_LEN(PU_LEN), .CAL_LEN(HOST_CAL))
   cis_seq_asserts_inst (.clk_i(clk_i), .resetn_i(resetn_i),
      .reset_pin(link_if.reset_pin),
      .reference_select_pin(link_if.reference_select_pin),
      .serial_port_enable_n(link_if.serial_port_enable_n),
      .serial_clk(link_if.serial_clk), .serial_din(link_if.serial_din),
      .serial_dout(link_if.serial_dout));

   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;

   function automatic logic [7:0] exp_read(input logic [6:0] ad,
      input logic [7:0] cfg, input logic rf);
      if (ad == REG_CONFIG)
         return cfg;
      if (ad == REG_STATUS)
         return {6'h00, rf, 1'b0};
      return 8'h00;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wait_ready();
      n = 0;
      while (ready_o !== 1'b1 && n < 2000)
      begin
         @(negedge clk_i);
         n++;
      end
      check({7'h00, ready_o}, 8'h01);
   endtask

   // Requests only while ready, else the host drops them silently
   task automatic op(input logic rd, input logic [6:0] ad,
      input logic [7:0] v, output logic [7:0] q);
      wait_ready();
      req_read_i = rd;
      req_addr_i = ad;
      req_data_i = v;
      req_i = 1'b1;
      @(negedge clk_i);
      req_i = 1'b0;
      n = 0;
      while (rd && rd_valid_o !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      q = rd ? rd_data_o : 8'h00;
      wait_ready();
   endtask

   task automatic kick(input logic hw);
      wait_ready();
      hw_reset_i = hw;
      sw_reset_i = ~hw;
      @(negedge clk_i);
      {hw_reset_i, sw_reset_i} = 2'b00;
   endtask

   task automatic count_busy();
      n = 0;
      while (busy_o === 1'b1 && n < 1000)
      begin
         @(negedge clk_i);
         n++;
      end
      check({7'h00, n >= CAL && n <= CAL + 8}, 8'h01);
   endtask

   initial
   begin
      #(20000 * 10);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end

   initial
   begin
      {resetn_i, req_i, req_read_i, sw_reset_i, hw_reset_i} = 5'b00000;
      ref_level_i = 1'b1;
      req_addr_i = 7'h00;
      req_data_i = 8'h00;
      fails = 0;
      cmp_count = 0;
      void'($urandom(32'h90de));
      repeat (2) @(negedge clk_i);
      resetn_i = 1'b1;
      wait_ready();
      check({6'h00, ref_select_o, busy_o}, 8'h02);
      check(config_o, CONFIG_FUSE_DEFAULT);
      op(1'b1, REG_STATUS, 8'h00, rdq);
      check(rdq, exp_read(REG_STATUS, 8'h00, 1'b1));
      op(1'b1, REG_GLOBAL_SOFTWARE_RESET, 8'h00, rdq);
      check(rdq, SW_RESET_DEFAULT);
      for (int i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
         a = 7'h03 + 7'($urandom % 125);
         op(1'b0, REG_CONFIG, d, rdq);
         op(1'b0, a, ~d, rdq);
         op(1'b1, a, 8'h00, rdq);
         check(rdq, exp_read(a, d, 1'b1));
         op(1'b1, REG_CONFIG, 8'h00, rdq);
         check(rdq, exp_read(REG_CONFIG, d, 1'b1));
         check(config_o, d);
      end
      op(1'b0, REG_CONFIG, 8'ha5, rdq);
      kick(1'b0);
      n = 0;
      while (busy_o !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      check({7'h00, busy_o}, 8'h01);
      count_busy();
      wait_ready();
      check(config_o, CONFIG_FUSE_DEFAULT);
      op(1'b1, REG_GLOBAL_SOFTWARE_RESET, 8'h00, rdq);
      check(rdq, SW_RESET_DEFAULT);
      op(1'b0, REG_CONFIG, 8'h3c, rdq);
      ref_level_i = 1'b0;
      kick(1'b1);
      n = 0;
      while (link_if.reset_pin !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      n = 0;
      while (link_if.reset_pin === 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      check({7'h00, n >= RESET_PULSE_CYCLES}, 8'h01);
      count_busy();
      wait_ready();
      check({6'h00, ref_select_o, busy_o}, 8'h00);
      check(config_o, CONFIG_FUSE_DEFAULT);
      op(1'b1, REG_STATUS, 8'h00, rdq);
      check(rdq, exp_read(REG_STATUS, 8'h00, 1'b0));
      end_of_test();
   end
endmodule
`default_nettype wire
